// ===== core/scs_map.svh
// Offsets, field positions, reset values and timing counts of the serial command port
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// Word layout
`define SCS_WORD_W        20
`define SCS_CHAIN_W       40
`define SCS_BITS_W        6
`define SCS_MIN_BITS      6'h14
`define SCS_MAX_BITS      6'h28
`define SCS_SEL_HI        19
`define SCS_SEL_LO        17
`define SCS_FMT_HI        5
`define SCS_FMT_LO        4
`define SCS_FMT_RST       2'h0

// Response layout
`define SCS_RSP_FIELD_HI  19
`define SCS_RSP_FIELD_LO  10
`define SCS_RSP_SE_HI     14
`define SCS_RSP_SE_LO     10
`define SCS_RSP_FLAG_HI   7
`define SCS_RSP_FLAG_LO   0

// Timing: system clock, input filter, serial clock made by the master end
`define SCS_CLK_NS        50
`define SCS_FILT_NS       20
`define SCS_FILT_CYC      (((`SCS_FILT_NS) + (`SCS_CLK_NS) - 1) / (`SCS_CLK_NS))
`define SCS_SCK_NS        400
`define SCS_HALF_CYC      ((((`SCS_SCK_NS) / 2) + (`SCS_CLK_NS) - 1) / (`SCS_CLK_NS))
`define SCS_GAP_CYC       8

`endif

// ===== core/scs_pkg.sv
// Types shared by both ends of the serial command port
package scs_pkg;

    // Register addressed by a latched command
    typedef enum logic [2:0] {
        SCS_TGT_DRV_CTRL  = 3'b000,
        SCS_TGT_CHOP_CONF = 3'b001,
        SCS_TGT_LOAD_CONF = 3'b010,
        SCS_TGT_STALL_CONF = 3'b011,
        SCS_TGT_DRV_CONF  = 3'b100
    } scs_target_t;

    // Master end sequencer
    typedef enum logic [2:0] {
        SCS_ST_IDLE  = 3'b000,
        SCS_ST_LEAD  = 3'b001,
        SCS_ST_LOW   = 3'b010,
        SCS_ST_HIGH  = 3'b011,
        SCS_ST_TRAIL = 3'b100,
        SCS_ST_GAP   = 3'b101
    } scs_state_t;

    // Device end, system clock domain; index 0 is select, index 1 driver disable
    typedef struct packed {
        logic [1:0][1:0] sync;
        logic [1:0][1:0] cnt;
        logic [1:0]      filt;
        logic [19:0]     cmd;
        logic            cmd_valid;
        scs_target_t     target;
        logic [1:0]      resp_fmt;
        logic [19:0]     resp;
    } scs_dev_sys_t;

    // Device end, link clock domain
    typedef struct packed {
        logic [19:0] shift;
    } scs_dev_link_t;

    // Master end
    typedef struct packed {
        scs_state_t  state;
        logic [3:0]  tim;
        logic [5:0]  bits_left;
        logic [39:0] tx;
        logic [39:0] rx;
        logic [1:0]  sdo_sync;
        logic        sck;
        logic        sdi;
        logic        csl;
        logic        busy;
        logic        done;
    } scs_host_t;

endpackage : scs_pkg

// ===== core/scs_link_if.sv
// Four-wire serial link between the command master and the device
`timescale 1ns/1ps
`default_nettype none

interface scs_link_if;
    logic sck;
    logic sdi;
    logic chip_select_low;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;

    // Weak pull-up on the shared data-out wire when nobody drives it
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    modport dev (
        input  sck,
        input  sdi,
        input  chip_select_low,
        output sdo,
        output sdo_oe
    );

    modport host (
        output sck,
        output sdi,
        output chip_select_low,
        input  sdo_line
    );
endinterface : scs_link_if

`default_nettype wire

// ===== core/scs_dev.sv
// Device end: 20-bit command shift slave with pass-through and response word
`include "scs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module scs_dev
    import scs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    scs_link_if.dev          link,
    input  wire logic        driver_disable_input_in,
    input  wire logic [9:0]  mstep_in,
    input  wire logic [9:0]  load_in,
    input  wire logic [4:0]  scale_in,
    input  wire logic [7:0]  flags_in,
    output logic      [19:0] cmd_word_out,
    output logic             cmd_valid_out,
    output scs_target_t      cmd_target_out,
    output logic      [1:0]  response_format_select_out,
    output logic             driver_disable_out
);

    scs_dev_sys_t  r;
    scs_dev_sys_t  next_r;
    scs_dev_link_t l;
    scs_dev_link_t next_l;
    logic          first;
    logic          sdo;
    logic          sdo_oe;
    logic [1:0]    pin_act;
    logic          sel_rise;

    // Active-high view of the pins before the synchronisers
    assign pin_act = {driver_disable_input_in, ~link.chip_select_low};

    // System side: sync, filter, latch, decode, build response
    always_comb begin
        next_r           = r;
        next_r.cmd_valid = 1'b0;
        sel_rise         = 1'b0;
        for (int i = 0; i < 2; i++) begin
            next_r.sync[i] = {r.sync[i][0], pin_act[i]};
            // A level must hold past the filter time before it counts
            if (r.sync[i][1] == r.filt[i]) begin
                next_r.cnt[i] = 2'h0;
            end else if (r.cnt[i] >= 2'(`SCS_FILT_CYC)) begin
                next_r.filt[i] = r.sync[i][1];
                next_r.cnt[i]  = 2'h0;
            end else begin
                next_r.cnt[i] = r.cnt[i] + 2'h1;
            end
        end
        // Deselect edge: shift word is quiet, sck has stopped
        sel_rise = r.filt[0] & ~next_r.filt[0];
        if (sel_rise) begin
            next_r.cmd       = l.shift;
            next_r.cmd_valid = 1'b1;
            unique case (l.shift[`SCS_SEL_HI:`SCS_SEL_LO])
                3'b000, 3'b001: next_r.target = SCS_TGT_DRV_CTRL;
                3'b100:         next_r.target = SCS_TGT_CHOP_CONF;
                3'b101:         next_r.target = SCS_TGT_LOAD_CONF;
                3'b110:         next_r.target = SCS_TGT_STALL_CONF;
                3'b111:         next_r.target = SCS_TGT_DRV_CONF;
                default:        next_r.target = SCS_TGT_DRV_CTRL;
            endcase
            if (l.shift[`SCS_SEL_HI:`SCS_SEL_LO] == 3'b111) begin
                next_r.resp_fmt = l.shift[`SCS_FMT_HI:`SCS_FMT_LO];
            end
        end
        // Response only refreshed while deselected, so the link sees a still word
        if (!r.filt[0]) begin
            next_r.resp = 20'h00000;
            unique case (r.resp_fmt)
                2'h0: begin
                    next_r.resp[`SCS_RSP_FIELD_HI:`SCS_RSP_FIELD_LO] = mstep_in;
                    next_r.resp[`SCS_RSP_FLAG_HI:`SCS_RSP_FLAG_LO]   = flags_in;
                end
                2'h1: next_r.resp[`SCS_RSP_FIELD_HI:`SCS_RSP_FIELD_LO] = load_in;
                2'h2: begin
                    next_r.resp[`SCS_RSP_FIELD_HI:`SCS_RSP_SE_HI + 1] = load_in[9:5];
                    next_r.resp[`SCS_RSP_SE_HI:`SCS_RSP_SE_LO]        = scale_in;
                end
                2'h3: next_r.resp = 20'h00000;
            endcase
        end
    end

    // System state register
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Link side: first-edge flag, cleared by the first rising sck of a frame
    always_ff @(posedge link.sck or posedge link.chip_select_low) begin
        if (link.chip_select_low) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    // Shift input on rising sck; response enters on the first edge
    always_comb begin
        if (first) begin
            next_l.shift = {r.resp[18:0], link.sdi};
        end else begin
            next_l.shift = {l.shift[18:0], link.sdi};
        end
    end

    // Kept over deselect so the system side can latch it
    always_ff @(posedge link.sck) begin
        l <= next_l;
    end

    // Output changes on falling sck; released while deselected
    always_ff @(negedge link.sck or posedge link.chip_select_low) begin
        if (link.chip_select_low) begin
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            sdo    <= first ? r.resp[19] : l.shift[19];
            sdo_oe <= 1'b1;
        end
    end

    assign link.sdo                   = sdo;
    assign link.sdo_oe                = sdo_oe;
    assign cmd_word_out               = r.cmd;
    assign cmd_valid_out              = r.cmd_valid;
    assign cmd_target_out             = r.target;
    assign response_format_select_out = r.resp_fmt;
    assign driver_disable_out         = r.filt[1];

endmodule : scs_dev

`default_nettype wire

// ===== core/scs_host.sv
// Master end: frames 20 to 40 bits, makes the serial clock by division
`include "scs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module scs_host
    import scs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    scs_link_if.host         link,
    input  wire logic        start_in,
    input  wire logic [39:0] tx_data_in,
    input  wire logic [5:0]  tx_bits_in,
    output logic             busy_out,
    output logic             done_out,
    output logic      [39:0] rx_data_out
);

    scs_host_t r;
    scs_host_t next_r;

    // Divider-based sequencer; sck idles high so the device sees a fall first
    always_comb begin
        next_r          = r;
        next_r.done     = 1'b0;
        next_r.sdo_sync = {r.sdo_sync[0], link.sdo_line};
        if (r.tim != 4'h0) begin
            next_r.tim = r.tim - 4'h1;
        end
        unique case (r.state)
            SCS_ST_IDLE: begin
                if (start_in) begin
                    next_r.tx   = tx_data_in;
                    next_r.rx   = 40'h0000000000;
                    // Clamp length to one to two chained words
                    if (tx_bits_in < `SCS_MIN_BITS) begin
                        next_r.bits_left = `SCS_MIN_BITS;
                    end else if (tx_bits_in > `SCS_MAX_BITS) begin
                        next_r.bits_left = `SCS_MAX_BITS;
                    end else begin
                        next_r.bits_left = tx_bits_in;
                    end
                    next_r.csl   = 1'b0;
                    next_r.busy  = 1'b1;
                    next_r.tim   = 4'(`SCS_HALF_CYC - 1);
                    next_r.state = SCS_ST_LEAD;
                end
            end
            SCS_ST_LEAD, SCS_ST_HIGH: begin
                if (r.tim == 4'h0) begin
                    if (r.state == SCS_ST_HIGH && r.bits_left == 6'h00) begin
                        next_r.tim   = 4'(`SCS_HALF_CYC - 1);
                        next_r.state = SCS_ST_TRAIL;
                    end else begin
                        // Data changes with the falling edge, top bit first
                        next_r.sck   = 1'b0;
                        next_r.sdi   = r.tx[39];
                        next_r.tx    = {r.tx[38:0], 1'b0};
                        next_r.tim   = 4'(`SCS_HALF_CYC - 1);
                        next_r.state = SCS_ST_LOW;
                    end
                end
            end
            SCS_ST_LOW: begin
                if (r.tim == 4'h0) begin
                    // Synced sample is two cycles old, still inside the low phase
                    next_r.sck       = 1'b1;
                    next_r.rx        = {r.rx[38:0], r.sdo_sync[1]};
                    next_r.bits_left = r.bits_left - 6'h01;
                    next_r.tim       = 4'(`SCS_HALF_CYC - 1);
                    next_r.state     = SCS_ST_HIGH;
                end
            end
            SCS_ST_TRAIL: begin
                if (r.tim == 4'h0) begin
                    // Select held low without a break until here
                    next_r.csl   = 1'b1;
                    next_r.tim   = 4'(`SCS_GAP_CYC - 1);
                    next_r.state = SCS_ST_GAP;
                end
            end
            SCS_ST_GAP: begin
                // Long enough for the device to filter and latch the deselect
                if (r.tim == 4'h0) begin
                    next_r.busy  = 1'b0;
                    next_r.done  = 1'b1;
                    next_r.state = SCS_ST_IDLE;
                end
            end
            default: begin
                next_r.state = SCS_ST_IDLE;
            end
        endcase
    end

    // State register; link idles deselected with sck high
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            r          <= '0;
            r.sck      <= 1'b1;
            r.csl      <= 1'b1;
            r.sdo_sync <= 2'h3;
        end else begin
            r <= next_r;
        end
    end

    assign link.sck             = r.sck;
    assign link.sdi             = r.sdi;
    assign link.chip_select_low = r.csl;
    assign busy_out             = r.busy;
    assign done_out             = r.done;
    assign rx_data_out          = r.rx;

endmodule : scs_host

`default_nettype wire

// ===== tb/scs_link_asserts.sv
// Checker for the serial link between the master and device ends
`timescale 1ns/1ps
`default_nettype none

module scs_link_asserts (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic sck,
    input wire logic sdi,
    input wire logic chip_select_low,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_line
);
    logic [5:0] rises;

    // Rising serial edges in this frame; deselect clears it at once
    always_ff @(posedge sck or posedge chip_select_low) begin
        if (chip_select_low) begin
            rises <= 6'h00;
        end else if (rises != 6'h3f) begin
            rises <= rises + 6'h01;
        end
    end

    // Low half of a serial period is four system clocks
    sequence s_low_half;
        !sck [*4] ##1 sck;
    endsequence

    // High half of a serial period lasts at least four system clocks
    sequence s_high_half;
        sck [*4];
    endsequence

    // Deselect gap before the next frame may start
    sequence s_gap;
        chip_select_low [*8];
    endsequence

    a_idle_released: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) chip_select_low |-> !sdo_oe && sdo_line)
        else $error("data out driven while deselected");
    a_sck_idle_high: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) chip_select_low |-> sck)
        else $error("serial clock low outside a frame");
    a_out_after_fall: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !chip_select_low && $past(!chip_select_low) && sck && $past(sck) |-> $stable(sdo))
        else $error("data out moved while serial clock high");
    a_in_steady_high: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !chip_select_low && $past(!chip_select_low) && sck && $past(sck) |-> $stable(sdi))
        else $error("data in moved while serial clock high");
    a_low_half_time: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) $fell(sck) |-> s_low_half)
        else $error("serial clock low phase not four clocks");
    a_high_half_time: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) $rose(sck) |-> s_high_half)
        else $error("serial clock high phase under four clocks");
    a_deselect_gap: assert property (
        @(posedge clk_in) disable iff (!rst_b_in) $rose(chip_select_low) |-> s_gap)
        else $error("select high gap too short");
    a_oe_in_frame: assert property (
        @(posedge sck) disable iff (chip_select_low) sdo_oe)
        else $error("data out not driven inside a frame");
    a_chain_delay: assert property (
        @(posedge sck) disable iff (chip_select_low) rises >= 6'h14 |-> sdo == $past(sdi, 20))
        else $error("pass-through bit not twenty clocks late");
endmodule : scs_link_asserts

`default_nettype wire

// ===== tb/scs_tb.sv
// Bench: master and device ends joined by the link, user sides judged
`timescale 1ns/1ps
`default_nettype none

module scs_tb
    import scs_pkg::*;
;
    logic        clk_in;
    logic        rst_b_in;
    logic        start_in;
    logic        dis_in;
    logic [39:0] tx_data;
    logic [5:0]  tx_bits;
    logic [39:0] rx_data;
    logic [19:0] cmd_word;
    logic        busy, done, cmd_valid, dis_out;
    scs_target_t cmd_target;
    logic [1:0]  fmt;
    logic [9:0]  mstep_v = 10'h2d3;
    logic [9:0]  load_v = 10'h1b6;
    logic [4:0]  scale_v = 5'h15;
    logic [7:0]  flags_v = 8'ha7;
    int          miscompares = 0;
    int          check_count = 0;
    int          valid_seen = 0;

    scs_link_if link ();

    scs_host i_scs_host (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .link        (link.host),
        .start_in    (start_in),
        .tx_data_in  (tx_data),
        .tx_bits_in  (tx_bits),
        .busy_out    (busy),
        .done_out    (done),
        .rx_data_out (rx_data)
    );

    scs_dev i_scs_dev (
        .clk_in                     (clk_in),
        .rst_b_in                   (rst_b_in),
        .link                       (link.dev),
        .driver_disable_input_in    (dis_in),
        .mstep_in                   (mstep_v),
        .load_in                    (load_v),
        .scale_in                   (scale_v),
        .flags_in                   (flags_v),
        .cmd_word_out               (cmd_word),
        .cmd_valid_out              (cmd_valid),
        .cmd_target_out             (cmd_target),
        .response_format_select_out (fmt),
        .driver_disable_out         (dis_out)
    );

    scs_link_asserts i_scs_link_asserts (
        .clk_in          (clk_in),
        .rst_b_in        (rst_b_in),
        .sck             (link.sck),
        .sdi             (link.sdi),
        .chip_select_low (link.chip_select_low),
        .sdo             (link.sdo),
        .sdo_oe          (link.sdo_oe),
        .sdo_line        (link.sdo_line)
    );

    // System clock, 50 ns period
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // Count command pulses away from the active edge
    always @(negedge clk_in) begin
        if (cmd_valid === 1'b1) valid_seen++;
    end

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // One whole frame; bounded wait on the master's done pulse
    task automatic frame(input logic [39:0] data, input logic [5:0] bits);
        int n = 0;
        @(negedge clk_in);
        tx_data = data;
        tx_bits = bits;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        chk("busy set", 40'h1, 40'(busy));
        while (done !== 1'b1 && n < 1000) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 1000) begin
            miscompares++;
            summarize();
        end
        chk("busy clear", 40'h0, 40'(busy));
    endtask : frame

    // Expected status word for a format, built from the status inputs
    function automatic logic [19:0] resp_for(input logic [1:0] f);
        case (f)
            2'h0: return {mstep_v, 2'h0, flags_v};
            2'h1: return {load_v, 10'h000};
            2'h2: return {load_v[9:5], scale_v, 10'h000};
            default: return 20'h00000;
        endcase
    endfunction : resp_for

    // Every format, ending on format zero for the later tests
    task automatic t_formats();
        int v;
        for (int f = 3; f >= 0; f--) begin
            v = valid_seen;
            frame({20'he0a03 | 20'(f << 4), 20'h00000}, 6'h14);
            chk("valid count", 40'(v + 1), 40'(valid_seen));
            chk("conf target", 40'(SCS_TGT_DRV_CONF), 40'(cmd_target));
            chk("format", 40'(f), 40'(fmt));
            frame({20'h13579, 20'h00000}, 6'h14);
            chk("response", 40'(resp_for(2'(f))), 40'(rx_data[19:0]));
        end
        $display("t_formats done");
    endtask : t_formats

    // Target decode; format must hold through other targets
    task automatic t_targets();
        logic [19:0] cw [5] = '{20'h13579, 20'h3ffff, 20'h8abcd, 20'hafff0, 20'hc0f30};
        scs_target_t tg [5] = '{SCS_TGT_DRV_CTRL, SCS_TGT_DRV_CTRL, SCS_TGT_CHOP_CONF,
                                SCS_TGT_LOAD_CONF, SCS_TGT_STALL_CONF};
        for (int i = 0; i < 5; i++) begin
            frame({cw[i], 20'h00000}, 6'h14);
            chk("word", 40'(cw[i]), 40'(cmd_word));
            chk("target", 40'(tg[i]), 40'(cmd_target));
            chk("format kept", 40'h0, 40'(fmt));
        end
        $display("t_targets done");
    endtask : t_targets

    // Long frames: early bits pass through, last twenty are the command
    task automatic t_chain();
        frame({20'h5a5a5, 20'h3c3c3}, 6'h28);
        chk("chain out", {resp_for(2'h0), 20'h5a5a5}, rx_data);
        chk("chain cmd", 40'(20'h3c3c3), 40'(cmd_word));
        frame({24'hf12345, 16'h0000}, 6'h18);
        chk("odd out", 40'({resp_for(2'h0), 4'hf}), 40'(rx_data[23:0]));
        chk("odd cmd", 40'(20'h12345), 40'(cmd_word));
        $display("t_chain done");
    endtask : t_chain

    // A 15 ns pulse across one sampling edge must be filtered out
    task automatic t_filter();
        int n = 0;
        @(negedge clk_in);
        #20 dis_in = 1'b1;
        #15 dis_in = 1'b0;
        repeat (4) @(negedge clk_in);
        chk("glitch", 40'h0, 40'(dis_out));
        dis_in = 1'b1;
        while (dis_out !== 1'b1 && n < 10) begin
            @(negedge clk_in);
            n++;
        end
        chk("disable", 40'h1, 40'(dis_out));
        dis_in = 1'b0;
        $display("t_filter done");
    endtask : t_filter

    // Reset, then the scenarios in order
    initial begin
        rst_b_in = 1'b0;
        start_in = 1'b0;
        dis_in = 1'b0;
        tx_data = 40'h0;
        tx_bits = 6'h14;
        repeat (5) @(negedge clk_in);
        rst_b_in = 1'b1;
        chk("reset", 40'h0, 40'({busy, done, cmd_valid, fmt, cmd_word}));
        t_formats();
        t_targets();
        t_chain();
        t_filter();
        summarize();
    end
endmodule : scs_tb

`default_nettype wire
